// [bko_backoff.sv]
`timescale 1ns/1ps
`default_nettype none
module bko_backoff import bko_pkg::*; #(
  parameter logic [31:0] SEED = 32'h1d2c_3b4a
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq,
  input wire logic retry_wait_launch,
  input wire logic retry_counter_clear,
  output logic retry_wait_finished,
  output logic retry_limit_error,
  output logic gate_enable_out
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    bko_state_e state;
    logic [4:0] attempts;
    logic exhausted;
    logic [10:0] slot_cnt;
    logic [10:0] elapsed_slots;
    logic [6:0] cyc;
    logic [31:0] ctrl;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic [31:0] readdata;
    logic waitreq;
    logic irq;
    logic finished;
    logic limit_err;
    logic gate_en;
  } bko_top_s;

  localparam bko_top_s BKO_TOP_RST = '{
    state: wait_idle_state,
    attempts: 5'h00,
    exhausted: 1'b0,
    slot_cnt: 11'h000,
    elapsed_slots: 11'h000,
    cyc: 7'h00,
    ctrl: BKO_CTRL_RST,
    irq_stat: 2'h0,
    irq_mask: BKO_IRQ_MASK_RST,
    readdata: 32'h0000_0000,
    waitreq: 1'b1,
    irq: 1'b0,
    finished: 1'b0,
    limit_err: 1'b0,
    gate_en: 1'b0
  };

  bko_top_s st_ff;
  bko_top_s nxt_st;
  bko_rand_if rnd ();

  bko_slot_gen #(.SEED(SEED)) u_gen (
    .clock(clock),
    .nrst(nrst),
    .rnd(rnd)
  );

  // ----------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------
  logic shared_medium_mode;
  logic backpressure_enable;
  logic gigabit_mode;
  logic [4:0] attempt_limit;
  logic [7:0] extra_slots;
  logic [6:0] slot_last;
  logic [4:0] base_att;
  logic [4:0] next_att;

  assign shared_medium_mode = st_ff.ctrl[BKO_CTRL_SHARED_BIT];
  assign backpressure_enable = st_ff.ctrl[BKO_CTRL_BP_BIT];
  assign gigabit_mode = st_ff.ctrl[BKO_CTRL_GIG_BIT];
  assign attempt_limit = st_ff.ctrl[BKO_CTRL_LIMIT_LSB +: 5];
  assign extra_slots = st_ff.ctrl[BKO_CTRL_EXTRA_LSB +: 8];
  assign slot_last = gigabit_mode ? BKO_SLOT_CYC_BYTE : BKO_SLOT_CYC_NIBBLE;
  assign base_att = retry_counter_clear ? 5'h00 : st_ff.attempts;
  assign next_att = (base_att == 5'h1f) ? base_att : base_att + 5'h01;
  // k follows the attempt about to be made
  assign rnd.k = (next_att > 5'(BKO_K_MAX)) ? BKO_K_MAX : next_att[3:0];

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [31:0] bmask;
    logic [1:0] ev;
    logic [1:0] w1c;
    logic req_seen;
    logic commit_wr;
    bmask = 32'h0000_0000;
    ev = 2'h0;
    w1c = 2'h0;
    req_seen = (avs_read || avs_write) && st_ff.waitreq;
    commit_wr = avs_write && !st_ff.waitreq;
    nxt_st = st_ff;
    nxt_st.finished = 1'b0;
    nxt_st.limit_err = 1'b0;

    // Attempt counter lives across waits until cleared by the tx machine
    if (retry_counter_clear) begin
      nxt_st.attempts = 5'h00;
      nxt_st.exhausted = 1'b0;
    end

    unique case (st_ff.state)
      wait_idle_state: begin
        if (retry_wait_launch) begin
          if (base_att >= attempt_limit) begin
            // No more tries allowed: answer at once and flag it
            nxt_st.exhausted = 1'b1;
            nxt_st.limit_err = 1'b1;
            nxt_st.finished = 1'b1;
            ev[BKO_IRQ_LIMIT_BIT] = 1'b1;
          end else begin
            nxt_st.attempts = next_att;
            nxt_st.state = wait_counting_state;
            nxt_st.elapsed_slots = 11'h000;
            nxt_st.cyc = 7'h00;
            // Without a shared medium there is nothing to back off from
            nxt_st.slot_cnt = shared_medium_mode ?
              11'({1'b0, rnd.value}) + 11'({3'h0, extra_slots}) : 11'h000;
          end
        end
      end
      wait_counting_state: begin
        if (backpressure_enable || st_ff.elapsed_slots == st_ff.slot_cnt) begin
          nxt_st.state = wait_idle_state;
          nxt_st.finished = 1'b1;
          ev[BKO_IRQ_DONE_BIT] = 1'b1;
        end else if (st_ff.gate_en) begin
          // Time advances only on edges the gated clock would pass
          if (st_ff.cyc == slot_last) begin
            nxt_st.cyc = 7'h00;
            nxt_st.elapsed_slots = st_ff.elapsed_slots + 11'h001;
          end else begin
            nxt_st.cyc = st_ff.cyc + 7'h01;
          end
        end
      end
    endcase

    nxt_st.gate_en = (nxt_st.state == wait_counting_state);

    // Bus slave: one wait cycle, then the access completes
    nxt_st.waitreq = !req_seen;
    if (req_seen && avs_read) begin
      unique case (avs_address)
        BKO_OFS_CTRL: nxt_st.readdata = st_ff.ctrl;
        BKO_OFS_STATUS: nxt_st.readdata = {22'h0, st_ff.exhausted,
          st_ff.state == wait_counting_state, 3'h0, st_ff.attempts};
        BKO_OFS_IRQ_STAT: nxt_st.readdata = {30'h0, st_ff.irq_stat};
        BKO_OFS_IRQ_MASK: nxt_st.readdata = {30'h0, st_ff.irq_mask};
        default: nxt_st.readdata = 32'h0000_0000;
      endcase
    end
    for (int i = 0; i < 4; i++) begin
      bmask[i*8 +: 8] = {8{avs_byteenable[i]}};
    end
    if (commit_wr) begin
      unique case (avs_address)
        BKO_OFS_CTRL: nxt_st.ctrl = (st_ff.ctrl & ~bmask) | (avs_writedata & bmask);
        BKO_OFS_IRQ_STAT: w1c = avs_writedata[1:0] & bmask[1:0];
        BKO_OFS_IRQ_MASK: nxt_st.irq_mask = (st_ff.irq_mask & ~bmask[1:0]) | (avs_writedata[1:0] & bmask[1:0]);
        default: nxt_st.irq_mask = st_ff.irq_mask;
      endcase
    end

    // New events win over a clear in the same cycle
    nxt_st.irq_stat = (st_ff.irq_stat & ~w1c) | ev;
    nxt_st.irq = |(nxt_st.irq_stat & nxt_st.irq_mask);
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st_ff <= BKO_TOP_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign avs_readdata = st_ff.readdata;
  assign avs_waitrequest = st_ff.waitreq;
  assign irq = st_ff.irq;
  assign retry_wait_finished = st_ff.finished;
  assign retry_limit_error = st_ff.limit_err;
  assign gate_enable_out = st_ff.gate_en;

endmodule
`default_nettype wire

// [bko_pkg.sv]
// Notes on behaviour
// - After a collision the frame is retried until success or the attempt limit.
// - Attempt count of a frame persists until cleared, so retries precede later frames.
// - Retry wait is a whole number of 512-bit slot times after jamming.
// - Slot count r is uniform in 0 to 2^k-1, k = min(attempt, 10).
// - Exhausting the attempt limit is reported as an error.
// - Random source should correlate little with other stations.
// - Extra delay may be added; average wait never below the standard one.
// - Launch command moves the wait machine from idle to counting; once attempts reach the limit the code stays idle and finishes at once.
// - Counting ends when elapsed equals chosen slots, or at once under backpressure.
// - Active-low reset clears all backoff state asynchronously.
// - Wait is timed only while the clock gate enable is raised.
// - Counter-clear command resets the attempt counter.
package bko_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [3:0] BKO_OFS_CTRL = 4'h0;
  localparam logic [3:0] BKO_OFS_STATUS = 4'h4;
  localparam logic [3:0] BKO_OFS_IRQ_STAT = 4'h8;
  localparam logic [3:0] BKO_OFS_IRQ_MASK = 4'hc;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BKO_CTRL_SHARED_BIT = 0;
  localparam int BKO_CTRL_BP_BIT = 1;
  localparam int BKO_CTRL_GIG_BIT = 2;
  localparam int BKO_CTRL_LIMIT_LSB = 4;
  localparam int BKO_CTRL_EXTRA_LSB = 16;
  localparam int BKO_STAT_ATT_LSB = 0;
  localparam int BKO_STAT_COUNTING_BIT = 8;
  localparam int BKO_STAT_EXHAUSTED_BIT = 9;
  localparam int BKO_IRQ_DONE_BIT = 0;
  localparam int BKO_IRQ_LIMIT_BIT = 1;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] BKO_CTRL_RST = 32'h0000_0101;
  localparam logic [1:0] BKO_IRQ_MASK_RST = 2'h0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int BKO_SLOT_BITS = 512;
  localparam int BKO_BYTE_PATH_BITS = 8;
  localparam int BKO_NIBBLE_PATH_BITS = 4;
  localparam logic [6:0] BKO_SLOT_CYC_BYTE = 7'(BKO_SLOT_BITS / BKO_BYTE_PATH_BITS - 1);
  localparam logic [6:0] BKO_SLOT_CYC_NIBBLE = 7'(BKO_SLOT_BITS / BKO_NIBBLE_PATH_BITS - 1);
  localparam logic [3:0] BKO_K_MAX = 4'ha;

  typedef enum logic [0:0] {
    wait_idle_state = 1'b0,
    wait_counting_state = 1'b1
  } bko_state_e;

endpackage

// [bko_rand_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface bko_rand_if;
  logic [3:0] k;
  logic [9:0] value;
  modport gen (input k, output value);
  modport user (output k, input value);
endinterface
`default_nettype wire

// [bko_slot_gen.sv]
`timescale 1ns/1ps
`default_nettype none
module bko_slot_gen import bko_pkg::*; #(
  // Seed value is arbitrary; give each station its own to decorrelate
  parameter logic [31:0] SEED = 32'h1d2c_3b4a
) (
  input wire logic clock,
  input wire logic nrst,
  bko_rand_if.gen rnd
);

  typedef struct packed {
    logic [31:0] lfsr;
  } bko_gen_s;

  bko_gen_s st_ff;
  bko_gen_s nxt_st;
  logic [9:0] mask;

  always_comb begin
    nxt_st = st_ff;
    // Free-running, advances every cycle regardless of launches
    nxt_st.lfsr = {st_ff.lfsr[30:0], st_ff.lfsr[31] ^ st_ff.lfsr[21] ^ st_ff.lfsr[1] ^ st_ff.lfsr[0]};
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st_ff <= '{lfsr: SEED};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign mask = 10'((11'h001 << rnd.k) - 11'h001);
  assign rnd.value = st_ff.lfsr[9:0] & mask;

endmodule
`default_nettype wire

// [bko_backoff_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
module bko_backoff_asserts (
  input wire logic clock,
  input wire logic nrst,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic retry_wait_launch,
  input wire logic retry_wait_finished,
  input wire logic retry_limit_error,
  input wire logic gate_enable_out
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  property p_bus_answer;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("bus answer late");
  property p_bus_pulse;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_bus_pulse: assert property (p_bus_pulse) else $error("waitrequest low too long");
  property p_launch;
    retry_wait_launch && !gate_enable_out |=> gate_enable_out || retry_wait_finished;
  endproperty
  a_launch: assert property (p_launch) else $error("launch ignored");
  property p_gate_cause;
    $rose(gate_enable_out) |-> $past(retry_wait_launch);
  endproperty
  a_gate_cause: assert property (p_gate_cause) else $error("gate without launch");
  property p_gate_stays;
    gate_enable_out |=> gate_enable_out || retry_wait_finished;
  endproperty
  a_gate_stays: assert property (p_gate_stays) else $error("count dropped");
  property p_gate_end;
    $fell(gate_enable_out) |-> retry_wait_finished;
  endproperty
  a_gate_end: assert property (p_gate_end) else $error("gate fell alone");
  property p_finish;
    retry_wait_finished && !retry_wait_launch |=> !retry_wait_finished;
  endproperty
  a_finish: assert property (p_finish) else $error("finish not a pulse");
  property p_limit;
    retry_limit_error |-> retry_wait_finished && !gate_enable_out;
  endproperty
  a_limit: assert property (p_limit) else $error("limit error alone");
endmodule
bind bko_backoff bko_backoff_asserts bko_backoff_asserts_inst (.clock(clock), .nrst(nrst),
  .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
  .retry_wait_launch(retry_wait_launch), .retry_wait_finished(retry_wait_finished),
  .retry_limit_error(retry_limit_error), .gate_enable_out(gate_enable_out));
`default_nettype wire

// [bko_txfsm_model.sv]
`timescale 1ns/1ps
`default_nettype none
module bko_txfsm_model (
  input wire logic clock,
  input wire logic retry_wait_finished,
  output logic retry_wait_launch,
  output logic retry_counter_clear
);
  initial begin
    retry_wait_launch = 1'b0;
    retry_counter_clear = 1'b0;
  end
  // One-cycle pulse, so a held level cannot relaunch
  task automatic start(input logic clr);
    @(posedge clock);
    retry_wait_launch <= 1'b1;
    retry_counter_clear <= clr;
    @(posedge clock);
    retry_wait_launch <= 1'b0;
    retry_counter_clear <= 1'b0;
  endtask
  // No local limit: a hang is left to the bench watchdog
  task automatic wait_done(output int n);
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (retry_wait_finished !== 1'b1);
  endtask
endmodule
`default_nettype wire

// [testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import bko_pkg::*;
  logic clock = 1'b0;
  logic nrst, avs_read, avs_write, irq, launch, clear, finished, limit_error, gate, avs_waitrequest;
  logic [3:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  int err_count = 0;
  int checked = 0;
  int n;
  always #2 clock = ~clock;
  bko_backoff bko_backoff_inst (.clock(clock), .nrst(nrst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .irq(irq), .retry_wait_launch(launch), .retry_counter_clear(clear),
    .retry_wait_finished(finished), .retry_limit_error(limit_error), .gate_enable_out(gate));
  bko_txfsm_model bko_txfsm_model_inst (.clock(clock), .retry_wait_finished(finished),
    .retry_wait_launch(launch), .retry_counter_clear(clear));
  task complete_run;
    $display("errors %0d checks %0d", err_count, checked);
    if (err_count == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask
  task chk_rng(input string nm, input int lo, input int hi, input int g);
    checked++;
    if (g < lo || g > hi) begin
      err_count++;
      $display("unexpected %s exp %0d..%0d got %0d", nm, lo, hi, g);
    end
  endtask
  task bus(input logic [3:0] a, input logic w, input logic [31:0] d);
    @(posedge clock);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    do begin
      @(posedge clock);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task retry(input logic clr);
    bko_txfsm_model_inst.start(clr);
    bko_txfsm_model_inst.wait_done(n);
  endtask
  initial begin
    #100000;
    err_count++;
    complete_run();
  end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    {nrst, avs_read, avs_write, avs_address, avs_writedata} = '0;
    repeat (5) @(posedge clock);
    nrst <= 1'b1;
    bus(BKO_OFS_CTRL, 1'b0, 0); chk("ctrl", BKO_CTRL_RST, q);
    bus(BKO_OFS_IRQ_MASK, 1'b0, 0); chk("mask", 32'h0, q);
    bus(4'h2, 1'b0, 0); chk("unmapped", 32'h0, q);
    bus(BKO_OFS_CTRL, 1'b1, 32'h0000_0100);
    retry(1'b1); chk_rng("wait r0", 2, 2, n);
    chk("irq masked", 1'b0, irq);
    bus(BKO_OFS_IRQ_STAT, 1'b0, 0); chk("stat", 32'h1, q);
    bus(BKO_OFS_IRQ_MASK, 1'b1, 32'h1);
    repeat (3) @(posedge clock); chk("irq on", 1'b1, irq);
    bus(BKO_OFS_IRQ_STAT, 1'b1, 32'h1);
    repeat (3) @(posedge clock); chk("irq w1c", 1'b0, irq);
    bus(BKO_OFS_CTRL, 1'b1, 32'h0000_0103);
    retry(1'b0); chk_rng("bp wait", 2, 2, n);
    // Shared medium on, one extra slot: attempt 1 gives 1 or 2 slots
    for (int g = 0; g < 2; g++) begin
      bus(BKO_OFS_CTRL, 1'b1, 32'h0001_0101 | (g << 2));
      retry(1'b1); chk_rng("slot", g ? 66 : 130, g ? 130 : 258, n);
      chk("slot whole", 0, (n - 2) % (g ? 64 : 128));
    end
    // Limit of two attempts, shared medium off
    bus(BKO_OFS_CTRL, 1'b1, 32'h0000_0020);
    retry(1'b1);
    retry(1'b0);
    bus(BKO_OFS_STATUS, 1'b0, 0); chk("attempts", 32'h2, q & 32'h1f);
    retry(1'b0); chk("limit", 1'b1, limit_error);
    chk_rng("limit wait", 1, 1, n);
    bus(BKO_OFS_STATUS, 1'b0, 0); chk("exhausted", 1'b1, q[9]);
    retry(1'b1);
    bus(BKO_OFS_STATUS, 1'b0, 0); chk("cleared", 32'h1, q & 32'h1f);
    bus(BKO_OFS_CTRL, 1'b1, 32'h0000_0105);
    for (int k = 1; k < 5; k++) begin
      retry(k == 1); chk_rng("random", 2, 2 + ((1 << k) - 1) * 64, n);
      chk("random whole", 0, (n - 2) % 64);
    end
    // Long wait cut by reset
    bus(BKO_OFS_CTRL, 1'b1, 32'h00ff_0105);
    bko_txfsm_model_inst.start(1'b1);
    repeat (10) @(posedge clock);
    chk("gate on", 1'b1, gate);
    nrst <= 1'b0;
    @(posedge clock);
    chk("gate reset", 1'b0, gate);
    nrst <= 1'b1;
    bus(BKO_OFS_CTRL, 1'b0, 0); chk("ctrl again", BKO_CTRL_RST, q);
    complete_run();
  end
endmodule
`default_nettype wire
